// File: test_regs.svh
// register offsets, field positions, reset values and codes for the test register bank
// How it works
// - bit 6 of self-test control drives non-linear receive gain output.
// - adjust clear: frame-width 1 gives maximum, 0 gives minimum frame length.
// - adjust and width set: start high 2 ETU+8, lows 11 ETU-8 clocks.
// - self-test enabled only while self-test field holds 1001b.
// - checksum command also starts the enabled self-test.
// - read-only 8-bit revision code readable by software.
// - each aux pin follows its selector: 0000 tri-state, 1010 high, 1011 low.
// - code 0001 routes first DAC value to pin one, second to pin two.
// - codes 0100, 0101, 0110 put threshold, I sample, Q sample onto DAC.
// - codes 0011, 0111, 1000, 1001 reserved; 1000 carries production test signal.
// - code 1100 outputs transmit activity.
// - code 1101 outputs receive activity.
// - code 1110 outputs subcarrier detection.
// - code 1111 outputs the chosen test bus bit.
// - first selector bits 7 to 4, second bits 3 to 0, same table.
// - 6-bit first DAC test value in low bits; bit 6 reserved, bit 7 stored and read back.
// - 3-bit bus bit choice picks the test bus bit for code 1111.
`ifndef TEST_REGS_SVH
`define TEST_REGS_SVH
// ==========================================
// offsets
`define SELFTEST_CTRL_ADDR 6'h36
`define REVISION_ADDR      6'h37
`define AUX_SELECT_ADDR    6'h38
`define DAC1_VALUE_ADDR    6'h39
`define DAC2_VALUE_ADDR    6'h3A
`define BUS_CHOICE_ADDR    6'h31
// ==========================================
// fields and reset values
`define SELFTEST_CTRL_RST  8'h40
`define SELFTEST_CTRL_MASK 8'hDF
`define NONLIN_BIT         6
`define ADJUST_BIT         4
`define SELFTEST_ON_CODE   4'h9
`define AUX_SELECT_RST     8'h00
`define DAC_VALUE_MASK     8'h3F
`define BUS_CHOICE_MASK    8'h07
// ==========================================
// frame timing, in ETU and clocks
`define SOF_HIGH_ETU       2
`define SOF_LOW_ETU        11
`define FRAME_TRIM_CLK     8
`endif

// File: test_pkg.sv
// types for the test register bank
`default_nettype none
package test_pkg;
  typedef enum logic [3:0] {
    SEL_TRISTATE = 4'h0, SEL_DAC_VALUE = 4'h1, SEL_CORR = 4'h2, SEL_RES3 = 4'h3,
    SEL_MINLEVEL = 4'h4, SEL_ADC_I = 4'h5, SEL_ADC_Q = 4'h6, SEL_RES7 = 4'h7,
    SEL_PROD = 4'h8, SEL_RES9 = 4'h9, SEL_HIGH = 4'hA, SEL_LOW = 4'hB,
    SEL_TX_ACT = 4'hC, SEL_RX_ACT = 4'hD, SEL_SUBCARRIER = 4'hE, SEL_BUS_BIT = 4'hF
  } aux_sel_t;
  typedef logic [5:0] dac_word_t;
  typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// File: test_regbank.sv
// test and self-test register bank with auxiliary pin selection
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "test_regs.svh"
module test_regbank #(
  parameter logic [7:0] REVISION_CODE = 8'h5A // arbitrary value
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  // register port
  input  wire logic [5:0]        ADDR,
  input  wire test_pkg::reg_byte_t WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic      [7:0]        RDATA,
  // internal sources
  input  wire logic              CHECKSUM_CMD,
  input  wire logic [7:0]        TEST_BUS,
  input  wire logic              TX_ACTIVE,
  input  wire logic              RX_ACTIVE,
  input  wire logic              SUBCARRIER_DET,
  input  wire logic              CORR_SIGNAL,
  input  wire logic              PROD_SIGNAL,
  input  wire logic [3:0]        MIN_THRESHOLD,
  input  wire logic [3:0]        ADC_I,
  input  wire logic [3:0]        ADC_Q,
  // receiver and frame controls
  output logic                   NONLINEAR_RECEIVE_GAIN,
  output logic                   FRAME_LENGTH_ADJUST,
  output logic                   FRAME_WIDTH_SELECT,
  output logic                   SELFTEST_ENABLE,
  output logic                   SELFTEST_START,
  // auxiliary pins: digital level, enable, analog level
  output logic                   FIRST_AUXILIARY_PIN_OUT,
  output logic                   FIRST_AUXILIARY_PIN_OE,
  output test_pkg::dac_word_t    FIRST_AUXILIARY_PIN_DAC,
  output logic                   SECOND_AUXILIARY_PIN_OUT,
  output logic                   SECOND_AUXILIARY_PIN_OE,
  output test_pkg::dac_word_t    SECOND_AUXILIARY_PIN_DAC,
  // frame timing requests in ETU and clock trims
  output logic [3:0]             SOF_HIGH_ETU,
  output logic [3:0]             SOF_LOW_ETU,
  output logic [3:0]             FRAME_TRIM,
  output logic                   FRAME_TRIM_SIGN
);
  import test_pkg::*;

  reg_byte_t ctrl_q;
  reg_byte_t aux_q;
  dac_word_t dac1_q;
  dac_word_t dac2_q;
  logic      dac1_prod_q;
  logic [2:0] choice_q;
  logic       frame_width_q;
  logic       bus_bit;
  logic [1:0] pin_out_d;
  logic [1:0] pin_oe_d;
  dac_word_t  pin_dac_d [2];
  reg_byte_t  rdata_d;

  // ==========================================
  // decode helpers
  function automatic logic write_hit(input logic [5:0] target);
    return WR_STB && (ADDR == target);
  endfunction

  function automatic logic selftest_on(input logic [3:0] code);
    return code == `SELFTEST_ON_CODE;
  endfunction

  // ==========================================
  // register writes
  // reserved bits dropped
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= `SELFTEST_CTRL_RST;
    end else if (write_hit(`SELFTEST_CTRL_ADDR)) begin
      ctrl_q <= WDATA & `SELFTEST_CTRL_MASK;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_q <= `AUX_SELECT_RST;
    end else if (write_hit(`AUX_SELECT_ADDR)) begin
      aux_q <= WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac1_q      <= 6'h00;
      dac1_prod_q <= 1'b0;
    end else if (write_hit(`DAC1_VALUE_ADDR)) begin
      dac1_q      <= WDATA[5:0];
      dac1_prod_q <= WDATA[7];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac2_q <= 6'h00;
    end else if (write_hit(`DAC2_VALUE_ADDR)) begin
      dac2_q <= WDATA[5:0];
    end
  end

  // bus bit choice and frame width
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      choice_q      <= 3'h0;
      frame_width_q <= 1'b0;
    end else if (write_hit(`BUS_CHOICE_ADDR)) begin
      choice_q      <= WDATA[2:0];
      frame_width_q <= WDATA[7];
    end
  end

  // ==========================================
  // read path
  // revision readback
  always_comb begin
    if (ADDR == `SELFTEST_CTRL_ADDR) begin
      rdata_d = ctrl_q;
    end else if (ADDR == `REVISION_ADDR) begin
      rdata_d = REVISION_CODE;
    end else if (ADDR == `AUX_SELECT_ADDR) begin
      rdata_d = aux_q;
    end else if (ADDR == `DAC1_VALUE_ADDR) begin
      rdata_d = {dac1_prod_q, 1'b0, dac1_q};
    end else if (ADDR == `DAC2_VALUE_ADDR) begin
      rdata_d = {2'b00, dac2_q};
    end else if (ADDR == `BUS_CHOICE_ADDR) begin
      rdata_d = {frame_width_q, 4'h0, choice_q};
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD_STB) begin
      RDATA <= rdata_d;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ==========================================
  // receiver, frame and self-test controls
  // non-linear gain
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      NONLINEAR_RECEIVE_GAIN <= 1'b0;
      FRAME_LENGTH_ADJUST    <= 1'b0;
      FRAME_WIDTH_SELECT     <= 1'b0;
    end else begin
      NONLINEAR_RECEIVE_GAIN <= ctrl_q[`NONLIN_BIT];
      FRAME_LENGTH_ADJUST    <= ctrl_q[`ADJUST_BIT];
      FRAME_WIDTH_SELECT     <= frame_width_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SELFTEST_ENABLE <= 1'b0;
    end else begin
      SELFTEST_ENABLE <= selftest_on(ctrl_q[3:0]);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SELFTEST_START <= 1'b0;
    end else begin
      SELFTEST_START <= CHECKSUM_CMD && selftest_on(ctrl_q[3:0]);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SOF_HIGH_ETU    <= 4'h0;
      SOF_LOW_ETU     <= 4'h0;
      FRAME_TRIM      <= 4'h0;
      FRAME_TRIM_SIGN <= 1'b0;
    end else if (ctrl_q[`ADJUST_BIT] && frame_width_q) begin
      SOF_HIGH_ETU    <= 4'(`SOF_HIGH_ETU);
      SOF_LOW_ETU     <= 4'(`SOF_LOW_ETU);
      FRAME_TRIM      <= 4'(`FRAME_TRIM_CLK);
      FRAME_TRIM_SIGN <= 1'b1;
    end else begin
      SOF_HIGH_ETU    <= 4'h0;
      SOF_LOW_ETU     <= 4'h0;
      FRAME_TRIM      <= 4'h0;
      FRAME_TRIM_SIGN <= 1'b0;
    end
  end

  // ==========================================
  // auxiliary pin muxing
  // bus bit pick
  assign bus_bit = TEST_BUS[choice_q];

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      aux_sel_t sel;
      assign sel = aux_sel_t'(p == 0 ? aux_q[7:4] : aux_q[3:0]);
      always_comb begin
        pin_out_d[p] = 1'b0;
        pin_oe_d[p]  = 1'b1;
        pin_dac_d[p] = 6'h00;
        case (sel)
          SEL_TRISTATE: pin_oe_d[p] = 1'b0;
          SEL_HIGH:     pin_out_d[p] = 1'b1;
          SEL_LOW:      pin_out_d[p] = 1'b0;
          SEL_DAC_VALUE: pin_dac_d[p] = (p == 0) ? dac1_q : dac2_q;
          SEL_CORR:      pin_out_d[p] = CORR_SIGNAL;
          SEL_MINLEVEL: pin_dac_d[p] = {2'b00, MIN_THRESHOLD};
          SEL_ADC_I:    pin_dac_d[p] = {2'b00, ADC_I};
          SEL_ADC_Q:    pin_dac_d[p] = {2'b00, ADC_Q};
          SEL_PROD: pin_out_d[p] = PROD_SIGNAL;
          SEL_TX_ACT: pin_out_d[p] = TX_ACTIVE;
          SEL_RX_ACT: pin_out_d[p] = RX_ACTIVE;
          SEL_SUBCARRIER: pin_out_d[p] = SUBCARRIER_DET;
          SEL_BUS_BIT: pin_out_d[p] = bus_bit;
          default: pin_oe_d[p] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIRST_AUXILIARY_PIN_OUT <= 1'b0;
      FIRST_AUXILIARY_PIN_OE  <= 1'b0;
      FIRST_AUXILIARY_PIN_DAC <= 6'h00;
      SECOND_AUXILIARY_PIN_OUT <= 1'b0;
      SECOND_AUXILIARY_PIN_OE  <= 1'b0;
      SECOND_AUXILIARY_PIN_DAC <= 6'h00;
    end else begin
      FIRST_AUXILIARY_PIN_OUT <= pin_out_d[0];
      FIRST_AUXILIARY_PIN_OE  <= pin_oe_d[0];
      FIRST_AUXILIARY_PIN_DAC <= pin_dac_d[0];
      SECOND_AUXILIARY_PIN_OUT <= pin_out_d[1];
      SECOND_AUXILIARY_PIN_OE  <= pin_oe_d[1];
      SECOND_AUXILIARY_PIN_DAC <= pin_dac_d[1];
    end
  end

  // ==========================================
  // checks
  selftest_code_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SELFTEST_ENABLE == ($past(ctrl_q[3:0]) == 4'h9))
    else $error("self-test enable does not follow code 1001");
  selftest_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SELFTEST_START |-> $past(CHECKSUM_CMD) && SELFTEST_ENABLE)
    else $error("self-test start without command or enable");
  nonlin_gain_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(RST_N) |-> NONLINEAR_RECEIVE_GAIN == $past(ctrl_q[6]))
    else $error("gain output does not follow bit 6");
  frame_adjust_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(ctrl_q[4]) && $past(frame_width_q) |-> SOF_HIGH_ETU == 4'h2 && SOF_LOW_ETU == 4'hB && FRAME_TRIM == 4'h8)
    else $error("adjusted frame figures wrong");
  aux_tristate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h0 |-> !FIRST_AUXILIARY_PIN_OE)
    else $error("pin one driven while tri-state");
  aux_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[3:0]) == 4'hA |-> SECOND_AUXILIARY_PIN_OE && SECOND_AUXILIARY_PIN_OUT)
    else $error("pin two not high");
  aux_dac_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h1 |-> FIRST_AUXILIARY_PIN_DAC == $past(dac1_q))
    else $error("pin one dac value wrong");
  reserved_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD_STB && ADDR == 6'h39 |=> RDATA[6] == 1'b0)
    else $error("reserved bit read nonzero");
  bus_bit_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[3:0]) == 4'hF |-> SECOND_AUXILIARY_PIN_OUT == $past(bus_bit))
    else $error("pin two bus bit wrong");

  // ==========================================
  // control and frame checks
  adjust_follow_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(RST_N) |-> FRAME_LENGTH_ADJUST == $past(ctrl_q[4]))
    else $error("adjust output does not follow bit 4");
  width_follow_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(RST_N) |-> FRAME_WIDTH_SELECT == $past(frame_width_q))
    else $error("width output does not follow register");
  frame_plain_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !$past(ctrl_q[4]) |-> SOF_HIGH_ETU == 4'h0 && SOF_LOW_ETU == 4'h0 && FRAME_TRIM == 4'h0)
    else $error("frame figures set without adjust");
  trim_sign_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(ctrl_q[4]) && $past(frame_width_q) |-> FRAME_TRIM_SIGN)
    else $error("trim sign not set while adjusted");
  selftest_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !$past(CHECKSUM_CMD) |-> !SELFTEST_START)
    else $error("self-test start with no command");
  start_when_on_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(RST_N) && $past(CHECKSUM_CMD) && $past(ctrl_q[3:0]) == 4'h9 |-> SELFTEST_START)
    else $error("self-test start missing");

  // ==========================================
  // read path checks
  revision_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD_STB && ADDR == `REVISION_ADDR |=> RDATA == REVISION_CODE)
    else $error("revision code read wrong");
  read_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !RD_STB |=> RDATA == 8'h00)
    else $error("read data nonzero without read");
  ctrl_reserved_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD_STB && ADDR == `SELFTEST_CTRL_ADDR |=> RDATA[5] == 1'b0)
    else $error("control reserved bit read nonzero");
  dac2_reserved_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD_STB && ADDR == `DAC2_VALUE_ADDR |=> RDATA[7:6] == 2'h0)
    else $error("second dac reserved bits read nonzero");
  unmapped_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RD_STB && ADDR == 6'h3B |=> RDATA == 8'h00)
    else $error("unmapped address read nonzero");
  aux_store_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(WR_STB) && $past(ADDR) == `AUX_SELECT_ADDR |-> aux_q == $past(WDATA))
    else $error("selector write not stored");
  choice_store_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(WR_STB) && $past(ADDR) == `BUS_CHOICE_ADDR |-> choice_q == $past(WDATA[2:0]))
    else $error("bus bit choice write not stored");

  // ==========================================
  // pin checks
  aux_low_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'hB |-> FIRST_AUXILIARY_PIN_OE && !FIRST_AUXILIARY_PIN_OUT)
    else $error("pin one not low");
  second_auxiliary_pin_tristate_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[3:0]) == 4'h0 |-> !SECOND_AUXILIARY_PIN_OE)
    else $error("pin two driven while tri-state");
  second_auxiliary_pin_dac_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[3:0]) == 4'h1 |-> SECOND_AUXILIARY_PIN_DAC == $past(dac2_q))
    else $error("pin two dac value wrong");
  min_level_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h4 |-> FIRST_AUXILIARY_PIN_DAC == {2'h0, $past(MIN_THRESHOLD)})
    else $error("pin one threshold value wrong");
  adc_i_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[3:0]) == 4'h5 |-> SECOND_AUXILIARY_PIN_DAC == {2'h0, $past(ADC_I)})
    else $error("pin two in-phase value wrong");
  adc_q_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h6 |-> FIRST_AUXILIARY_PIN_DAC == {2'h0, $past(ADC_Q)})
    else $error("pin one quadrature value wrong");
  dac_pin_level_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h5 |-> FIRST_AUXILIARY_PIN_OE && !FIRST_AUXILIARY_PIN_OUT)
    else $error("pin one level wrong on dac code");
  prod_pin_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h8 |-> FIRST_AUXILIARY_PIN_OUT == $past(PROD_SIGNAL))
    else $error("pin one production signal wrong");
  reserved_code_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'h3 |-> !FIRST_AUXILIARY_PIN_OE)
    else $error("pin one driven on reserved code");
  tx_active_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'hC |-> FIRST_AUXILIARY_PIN_OUT == $past(TX_ACTIVE))
    else $error("pin one transmit activity wrong");
  rx_active_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[3:0]) == 4'hD |-> SECOND_AUXILIARY_PIN_OUT == $past(RX_ACTIVE))
    else $error("pin two receive activity wrong");
  subcarrier_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(aux_q[7:4]) == 4'hE |-> FIRST_AUXILIARY_PIN_OUT == $past(SUBCARRIER_DET))
    else $error("pin one subcarrier detect wrong");
endmodule
`default_nettype wire

// File: test_test_and_self_test_registers.sv
// self-checking bench for the test register bank
`timescale 1ns/10ps
`default_nettype none
`include "test_regs.svh"
module test_test_and_self_test_registers;
  import test_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  logic        ref_clk, rst_n, wr_stb, rd_stb, chk_cmd;
  logic        tx, rx, sub, corr, prod;
  logic [5:0]  addr;
  reg_byte_t   wdata;
  logic [7:0]  rdata, test_bus;
  logic [3:0]  min_t, adc_i, adc_q, sof_hi, sof_lo, trim;
  logic        nl_gain, fl_adj, fw_sel, st_en, st_start, trim_sign;
  logic        a1_out, a1_oe, a2_out, a2_oe;
  dac_word_t   a1_dac, a2_dac;
  logic [7:0]  d, c, v, w, rv;
  logic [8:0]  e1, e2;
  integer      err_total, n_checks, seed, cyc, i;
  test_regbank #(.REVISION_CODE(REV)) u_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .CHECKSUM_CMD(chk_cmd), .TEST_BUS(test_bus),
    .TX_ACTIVE(tx), .RX_ACTIVE(rx), .SUBCARRIER_DET(sub), .CORR_SIGNAL(corr),
    .PROD_SIGNAL(prod), .MIN_THRESHOLD(min_t), .ADC_I(adc_i), .ADC_Q(adc_q),
    .NONLINEAR_RECEIVE_GAIN(nl_gain), .FRAME_LENGTH_ADJUST(fl_adj), .FRAME_WIDTH_SELECT(fw_sel),
    .SELFTEST_ENABLE(st_en), .SELFTEST_START(st_start), .FIRST_AUXILIARY_PIN_OUT(a1_out), .FIRST_AUXILIARY_PIN_OE(a1_oe),
    .FIRST_AUXILIARY_PIN_DAC(a1_dac), .SECOND_AUXILIARY_PIN_OUT(a2_out), .SECOND_AUXILIARY_PIN_OE(a2_oe), .SECOND_AUXILIARY_PIN_DAC(a2_dac),
    .SOF_HIGH_ETU(sof_hi), .SOF_LOW_ETU(sof_lo), .FRAME_TRIM(trim), .FRAME_TRIM_SIGN(trim_sign));
  // ==========================================
  // clock, timeout
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  // ==========================================
  // bus tasks and compares
  task automatic wr(input logic [5:0] a, input logic [7:0] dv);
    @(posedge ref_clk);
    addr   <= a;
    wdata  <= dv;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] dv);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 dv = rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp_rd(input logic [7:0] exp, input logic [7:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("unexpected read at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic cmp_out(input logic [15:0] exp, input logic [15:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("unexpected output at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic new_sources();
    @(posedge ref_clk);
    {tx, rx, sub, corr, prod} <= 5'($random(seed));
    {min_t, adc_i, adc_q}     <= 12'($random(seed));
    test_bus                  <= 8'($random(seed));
  endtask
  // model of one pin: {dac valid, oe, out, dac}
  function automatic logic [8:0] pin_model(input logic [3:0] s, input logic [5:0] dv);
    case (s)
      4'h1: return {3'b110, dv};
      4'h2: return {2'b01, corr, 6'h00};
      4'h4: return {3'b110, 2'h0, min_t};
      4'h5: return {3'b110, 2'h0, adc_i};
      4'h6: return {3'b110, 2'h0, adc_q};
      4'h8: return {2'b01, prod, 6'h00};
      4'hA: return 9'h0C0;
      4'hB: return 9'h080;
      4'hC: return {2'b01, tx, 6'h00};
      4'hD: return {2'b01, rx, 6'h00};
      4'hE: return {2'b01, sub, 6'h00};
      4'hF: return {2'b01, test_bus[c[2:0]], 6'h00};
      default: return 9'h000;
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    {ref_clk, rst_n, wr_stb, rd_stb, chk_cmd, tx, rx, sub, corr, prod} = '0;
    {addr, wdata, test_bus, min_t, adc_i, adc_q} = '0;
    err_total = 0;
    n_checks  = 0;
    seed      = 40;
    cyc       = 0;
    c         = 8'h00;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
    cmp_out(16'h0001, {15'h0, nl_gain});
    rd(`SELFTEST_CTRL_ADDR, rv);
    cmp_rd(`SELFTEST_CTRL_RST, rv);
    rd(`AUX_SELECT_ADDR, rv);
    cmp_rd(`AUX_SELECT_RST, rv);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      c = 8'($random(seed));
      v = 8'($random(seed));
      w = 8'($random(seed));
      d[4] = i[1];
      c[7] = i[2];
      d[3:0] = i[0] ? `SELFTEST_ON_CODE : (i[2] ? 4'h0 : d[3:0]);
      wr(`SELFTEST_CTRL_ADDR, d);
      wr(`BUS_CHOICE_ADDR, c);
      wr(`DAC1_VALUE_ADDR, v);
      wr(`DAC2_VALUE_ADDR, w);
      wr(6'h3B, 8'hFF);
      settle();
      cmp_out({13'h0, d[6], d[4], c[7]}, {13'h0, nl_gain, fl_adj, fw_sel});
      cmp_out({15'h0, d[3:0] == 4'h9}, {15'h0, st_en});
      cmp_out((d[4] & c[7]) ? {3'h0, 4'h2, 4'hB, 4'h8, 1'b1} : 16'h0,
              {3'h0, sof_hi, sof_lo, trim, trim_sign});
      @(posedge ref_clk);
      chk_cmd <= 1'b1;
      @(posedge ref_clk);
      chk_cmd <= 1'b0;
      #1 cmp_out({15'h0, d[3:0] == 4'h9}, {15'h0, st_start});
      rd(`SELFTEST_CTRL_ADDR, rv);
      cmp_rd(d & `SELFTEST_CTRL_MASK, rv);
      rd(`REVISION_ADDR, rv);
      cmp_rd(REV, rv);
      rd(`BUS_CHOICE_ADDR, rv);
      cmp_rd(c & 8'h87, rv);
      rd(`DAC1_VALUE_ADDR, rv);
      cmp_rd(v & 8'hBF, rv);
      rd(`DAC2_VALUE_ADDR, rv);
      cmp_rd(w & `DAC_VALUE_MASK, rv);
      rd(6'h3B, rv);
      cmp_rd(8'h00, rv);
    end
    $display("test registers done");
    for (i = 0; i < 16; i++) begin
      new_sources();
      wr(`AUX_SELECT_ADDR, {i[3:0], ~i[3:0]});
      settle();
      e1 = pin_model(i[3:0], v[5:0]);
      e2 = pin_model(~i[3:0], w[5:0]);
      cmp_out({8'h0, e1[7:0]}, {8'h0, a1_oe, a1_out, a1_dac});
      cmp_out({8'h0, e2[7:0]}, {8'h0, a2_oe, a2_out, a2_dac});
    end
    $display("test aux pins done");
    wr(`SELFTEST_CTRL_ADDR, 8'h00);
    settle();
    cmp_out(16'h0000, {15'h0, st_en});
    $display("test normal mode done");
    complete_run();
  end
endmodule
`default_nettype wire
